// ==== wdt_rst_pkg.sv ====
// Contract
// - Watchdog runs after every reset; disable only works before end-of-init.
// - Watchdog overflow raises internal reset and pulls reset output low.
// - 16-bit counter clocked by clock/2 or clock/128 per prescale select.
// - Each service reloads counter high byte from the reload value.
// - At 50 MHz, FF with /2 gives 10.24 us; 00 with /128 gives 168 ms.
// - Reset input entry and release both pass a two-flop synchroniser; only power-up reset is asynchronous.
// - Warm reset: input low with programming pin high tristates I/O, output low.
// - After input negation, short transition cancels holds and aborts bus cycles.
// - Internal reset sequence lasts 1024 half periods, 512 CPU clocks.
// - With bidir enable set, drive reset input pin low during a software or watchdog sequence.
// - Every reset sequence ends by clearing the bidir enable bit.
// - At sequence end, sample reset input; hold reset while still active.
// - Software reset instruction starts sequence any time; bidir drives pin low.
// - Watchdog reset completes or aborts a running bus cycle, then sequences.
// - No watchdog reset while in bootstrap loader mode.
// - Bidir makes watchdog/software reset visible on pin for the whole sequence.
package wdt_rst_pkg;
  localparam int          CLK_MHZ         = 100;
  localparam int          SEQ_HALF_CLKS   = 1024;              // Sequence length in half periods
  localparam int          SEQ_CYCLES      = SEQ_HALF_CLKS / 2;
  localparam logic [9:0]  SEQ_LAST        = 10'(SEQ_CYCLES - 1);
  localparam int          TRANS_CYCLES    = 4;                 // Transition period length
  localparam logic [2:0]  TRANS_LAST      = 3'(TRANS_CYCLES - 1);
  localparam int          CHECK_CYCLES    = 3;                 // Settle time before input sample
  localparam logic [1:0]  CHECK_LAST      = 2'(CHECK_CYCLES - 1);
  localparam logic [6:0]  PRESC_MASK_FAST = 7'h01;             // Divide by 2
  localparam logic [6:0]  PRESC_MASK_SLOW = 7'h7f;             // Divide by 128
  localparam logic [15:0] WDT_RESET_VAL   = 16'h0000;
  localparam int          BIDIR_BIT       = 3;                 // Position in system config
  typedef enum logic [2:0] {
    ST_RUN, ST_BUS_WAIT, ST_HOLD_IN, ST_TRANS, ST_SEQ, ST_CHECK
  } rst_state_t;
endpackage

// ==== wdt_evt_if.sv ====
`timescale 1ns/1ps
// Links watchdog counter to the reset sequencer
interface wdt_evt_if;
  logic overflow;
  logic wdt_reset;
  modport timer (output overflow, input wdt_reset);
  modport seq   (input overflow, output wdt_reset);
endinterface

// ==== wdt_counter.sv ====
`timescale 1ns/1ps
module wdt_counter (
  input  wire logic       i_clk,             // System clock
  input  wire logic       i_rst_b,           // Async reset
  input  wire logic       i_ce,              // Clock enable
  input  wire logic       i_enable,          // Watchdog running
  input  wire logic       i_service,         // Service pulse
  input  wire logic       i_presc_sel,       // Prescale select
  input  wire logic [7:0] i_reload,          // Reload value
  output logic      [15:0] o_count,          // Counter value
  wdt_evt_if.timer        evt                // Overflow to sequencer
);
  logic [6:0] presc_reg;
  logic [6:0] mask;
  logic       tick;
  assign mask = i_presc_sel ? wdt_rst_pkg::PRESC_MASK_SLOW
                            : wdt_rst_pkg::PRESC_MASK_FAST;
  assign tick = i_enable && ((presc_reg & mask) == mask);
  assign evt.overflow = tick && (o_count == 16'hffff) && !i_service;

  // Prescaler and counter; cleared by any internal reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_reg <= 7'h00;
      o_count   <= wdt_rst_pkg::WDT_RESET_VAL;
    end else if (i_ce) begin
      if (evt.wdt_reset) begin
        presc_reg <= 7'h00;
        o_count   <= wdt_rst_pkg::WDT_RESET_VAL;
      end else begin
        presc_reg <= presc_reg + 7'h01;
        if (i_service) begin
          o_count <= {i_reload, 8'h00};
        end else if (tick) begin
          o_count <= o_count + 16'h0001;
        end
      end
    end
  end
endmodule

// ==== watchdog_reset_sequencer.sv ====
`timescale 1ns/1ps
module watchdog_reset_sequencer (
  input  wire logic       i_clk,             // CPU clock
  input  wire logic       i_rst_b,           // Power-up async reset
  input  wire logic       i_ce,              // Clock enable
  input  wire logic       i_reset_input_pin, // Reset input pin level
  input  wire logic       i_vpp_pin,         // Programming voltage pin
  input  wire logic       i_wdt_disable,     // Software disable pulse
  input  wire logic       i_service,         // Watchdog service pulse
  input  wire logic       i_end_of_init,     // End-of-init instruction pulse
  input  wire logic       i_sw_reset,        // Software reset instruction pulse
  input  wire logic [7:0] i_reload_value,    // Watchdog reload value
  input  wire logic       i_prescale_select, // Watchdog prescale select
  input  wire logic       i_bidir_set,       // Write of bidir enable
  input  wire logic       i_bidir_wdata,     // Value for bidir enable
  input  wire logic       i_bootstrap_mode,  // Bootstrap loader mode
  input  wire logic       i_bus_active,      // External bus cycle running
  input  wire logic       i_bus_uses_ready,  // Cycle uses ready input
  input  wire logic       i_bus_ws_done,     // Programmed wait states done
  input  wire logic       i_ready_b,         // Ready input, active low
  output logic            o_internal_reset,  // Internal reset, active high
  output logic            o_reset_output_pin,// Reset output pin level
  output logic            o_reset_in_out,    // Value driven on reset input pin
  output logic            o_reset_in_oe,     // Drive enable of reset input pin
  output logic            o_io_tristate,     // I/O pins to high impedance
  output logic            o_bus_abort,       // Abort external bus cycle
  output logic            o_hold_cancel,     // Cancel pending hold states
  output logic            o_bidir_enable,    // Bidir enable bit state
  output logic            o_wdt_running,     // Watchdog running
  output logic [15:0]     o_wdt_count        // Watchdog counter value
);
  wdt_rst_pkg::rst_state_t state_reg, state_next;
  logic [9:0]  cnt_reg;
  logic [1:0]  rin_sync_reg;
  logic [1:0]  vpp_sync_reg;
  logic [1:0]  rdy_sync_reg;
  logic [1:0]  ws_dly_reg;
  logic        init_done_reg;
  logic        wdt_en_reg;
  logic        bidir_reg;
  logic        seq_bidir_reg;
  logic        wdt_rst_pulse;
  logic [15:0] count_w;
  logic        rin_low;
  logic        warm_start;
  logic        wdt_start;
  logic        bus_done;
  logic        bus_abort_w;
  logic        seq_end;
  logic        trans_end;
  logic        check_end;
  logic        in_reset;

  wdt_evt_if evt ();

  wdt_counter u_counter (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_enable    (wdt_en_reg && state_reg == wdt_rst_pkg::ST_RUN),
    .i_service   (i_service),
    .i_presc_sel (i_prescale_select),
    .i_reload    (i_reload_value),
    .o_count     (count_w),
    .evt         (evt)
  );

  // Decode of sequence triggers
  assign rin_low    = !rin_sync_reg[1];
  assign warm_start = rin_low && vpp_sync_reg[1];
  assign wdt_start  = evt.overflow && !i_bootstrap_mode;
  // Ready is judged only once its synchroniser has caught up with the wait states
  assign bus_done   = !i_bus_active || !i_bus_uses_ready
                      || (i_bus_ws_done && ws_dly_reg[1]
                          && !rdy_sync_reg[1]);
  assign bus_abort_w = i_bus_active && i_bus_uses_ready
                      && i_bus_ws_done && ws_dly_reg[1]
                      && rdy_sync_reg[1];
  assign seq_end    = (cnt_reg == wdt_rst_pkg::SEQ_LAST);
  assign trans_end  = (cnt_reg[2:0] == wdt_rst_pkg::TRANS_LAST);
  assign check_end  = (cnt_reg[1:0] == wdt_rst_pkg::CHECK_LAST);
  assign in_reset   = (state_next != wdt_rst_pkg::ST_RUN);
  assign wdt_rst_pulse = (state_reg == wdt_rst_pkg::ST_SEQ);
  assign evt.wdt_reset = wdt_rst_pulse;

  // Next-state logic for the reset sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wdt_rst_pkg::ST_RUN: begin
        if (warm_start) begin
          state_next = wdt_rst_pkg::ST_HOLD_IN;
        end else if (i_sw_reset) begin
          state_next = wdt_rst_pkg::ST_TRANS;
        end else if (wdt_start) begin
          state_next = wdt_rst_pkg::ST_BUS_WAIT;
        end
      end
      wdt_rst_pkg::ST_BUS_WAIT: begin
        if (bus_done || bus_abort_w) begin
          state_next = wdt_rst_pkg::ST_SEQ;
        end
      end
      wdt_rst_pkg::ST_HOLD_IN: begin
        if (!rin_low) begin
          state_next = wdt_rst_pkg::ST_TRANS;
        end
      end
      wdt_rst_pkg::ST_TRANS: begin
        if (trans_end) begin
          state_next = wdt_rst_pkg::ST_SEQ;
        end
      end
      wdt_rst_pkg::ST_SEQ: begin
        if (seq_end) begin
          state_next = wdt_rst_pkg::ST_CHECK;
        end
      end
      // Wait until our own pin drive has left the synchroniser, else it loops
      wdt_rst_pkg::ST_CHECK: begin
        if (check_end) begin
          state_next = rin_low ? wdt_rst_pkg::ST_HOLD_IN
                               : wdt_rst_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = wdt_rst_pkg::ST_RUN;
      end
    endcase
  end

  // Two-flop synchronisers for pins; release of reset input resynchronized
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rin_sync_reg <= 2'b00;
      vpp_sync_reg <= 2'b00;
      rdy_sync_reg <= 2'b11;
      ws_dly_reg   <= 2'b00;
    end else if (i_ce) begin
      ws_dly_reg   <= {ws_dly_reg[0], i_bus_ws_done};                    // Aligns with ready sync
      rin_sync_reg <= {rin_sync_reg[0], i_reset_input_pin};
      vpp_sync_reg <= {vpp_sync_reg[0], i_vpp_pin};
      rdy_sync_reg <= {rdy_sync_reg[0], i_ready_b};
    end
  end

  // State and sequence counter; power-up enters reset at once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= wdt_rst_pkg::ST_HOLD_IN;
      cnt_reg   <= 10'h000;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 10'h000;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end

  // Bidir enable: software sets, end of any sequence clears
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bidir_reg     <= 1'b0;
      seq_bidir_reg <= 1'b0;
    end else if (i_ce) begin
      if (state_reg == wdt_rst_pkg::ST_SEQ && seq_end) begin
        bidir_reg <= 1'b0;
      end else if (i_bidir_set && state_reg == wdt_rst_pkg::ST_RUN) begin
        bidir_reg <= i_bidir_wdata;
      end
      if (state_reg == wdt_rst_pkg::ST_RUN) begin
        seq_bidir_reg <= bidir_reg && (i_sw_reset || wdt_start)
                         && !warm_start;
      end else if (state_next == wdt_rst_pkg::ST_RUN
                   || state_reg == wdt_rst_pkg::ST_CHECK) begin
        seq_bidir_reg <= 1'b0;
      end
    end
  end

  // Watchdog enable and end-of-init tracking
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wdt_en_reg    <= 1'b1;
      init_done_reg <= 1'b0;
    end else if (i_ce) begin
      if (in_reset) begin
        wdt_en_reg    <= 1'b1;
        init_done_reg <= 1'b0;
      end else begin
        if (i_wdt_disable && !init_done_reg) begin
          wdt_en_reg <= 1'b0;
        end
        if (i_end_of_init) begin
          init_done_reg <= 1'b1;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_internal_reset   <= 1'b1;
      o_reset_output_pin <= 1'b0;
      o_reset_in_out     <= 1'b0;
      o_reset_in_oe      <= 1'b0;
      o_io_tristate      <= 1'b1;
      o_bus_abort        <= 1'b0;
      o_hold_cancel      <= 1'b0;
      o_bidir_enable     <= 1'b0;
      o_wdt_running      <= 1'b1;
      o_wdt_count        <= wdt_rst_pkg::WDT_RESET_VAL;
    end else if (i_ce) begin
      o_internal_reset   <= in_reset;
      o_reset_output_pin <= !in_reset && (init_done_reg || i_end_of_init);
      o_reset_in_out     <= 1'b0;
      o_reset_in_oe      <= seq_bidir_reg
                            && state_next == wdt_rst_pkg::ST_SEQ;
      o_io_tristate      <= in_reset;
      o_bus_abort        <= (state_next == wdt_rst_pkg::ST_TRANS)
                            || (state_reg == wdt_rst_pkg::ST_BUS_WAIT
                                && bus_abort_w);
      o_hold_cancel      <= (state_next == wdt_rst_pkg::ST_TRANS);
      o_bidir_enable     <= bidir_reg;
      o_wdt_running      <= wdt_en_reg;
      o_wdt_count        <= count_w;
    end
  end
endmodule

// ==== wdt_rst_sva.sv ====
`timescale 1ns/1ps
module wdt_rst_sva (
  input wire logic        i_clk,              // CPU clock
  input wire logic        i_rst_b,            // Async reset
  input wire logic        i_service,          // Service pulse
  input wire logic        i_end_of_init,      // End-of-init pulse
  input wire logic        i_sw_reset,         // Software reset pulse
  input wire logic [7:0]  i_reload_value,     // Reload value
  input wire logic        o_internal_reset,   // Internal reset
  input wire logic        o_reset_output_pin, // Reset output pin
  input wire logic        o_reset_in_out,     // Reset pin drive value
  input wire logic        o_reset_in_oe,      // Reset pin drive enable
  input wire logic        o_io_tristate,      // I/O high impedance
  input wire logic        o_bidir_enable,     // Bidir enable bit
  input wire logic        o_wdt_running,      // Watchdog running
  input wire logic [15:0] o_wdt_count         // Watchdog count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_oe_in_reset: assert property (o_reset_in_oe |-> o_internal_reset && !o_reset_in_out)
    else $error("reset pin driven outside a low reset");
  a_oe_held_long: assert property ($rose(o_reset_in_oe) |-> o_reset_in_oe [*8])
    else $error("reset pin drive too short");
  a_reset_out_low: assert property (o_internal_reset |-> !o_reset_output_pin)
    else $error("reset output high during reset");
  a_io_tristate_reset: assert property (o_internal_reset |-> o_io_tristate)
    else $error("I/O not tristated in reset");
  a_sw_reset_starts: assert property (i_sw_reset && !o_internal_reset |=> o_internal_reset)
    else $error("software reset not taken");
  a_bidir_cleared_end: assert property ($fell(o_internal_reset) |-> !o_bidir_enable)
    else $error("bidir enable survived reset");
  a_wdt_runs_after: assert property ($fell(o_internal_reset) |-> o_wdt_running)
    else $error("watchdog stopped after reset");
  a_out_after_init: assert property ($rose(o_reset_output_pin)
    |-> $past(i_end_of_init) || $past(i_end_of_init, 2))
    else $error("reset output released without end of init");
  a_service_reload_hi: assert property (i_service && !o_internal_reset
    |-> ##2 o_wdt_count[15:8] == $past(i_reload_value, 2))
    else $error("service did not reload high byte");
  c_oe_drive: cover property ($rose(o_reset_in_oe));
  c_reset_end: cover property ($fell(o_internal_reset));
  c_out_release: cover property ($rose(o_reset_output_pin));
endmodule
bind watchdog_reset_sequencer wdt_rst_sva chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_service(i_service), .i_end_of_init(i_end_of_init), .i_sw_reset(i_sw_reset),
  .i_reload_value(i_reload_value), .o_internal_reset(o_internal_reset),
  .o_reset_output_pin(o_reset_output_pin), .o_reset_in_out(o_reset_in_out),
  .o_reset_in_oe(o_reset_in_oe), .o_io_tristate(o_io_tristate),
  .o_bidir_enable(o_bidir_enable), .o_wdt_running(o_wdt_running), .o_wdt_count(o_wdt_count));

// ==== board_bus_model.sv ====
`timescale 1ns/1ps
module board_bus_model (
  input  wire logic i_clk,      // CPU clock
  input  wire logic i_oe,       // Device drives reset pin
  input  wire logic i_out,      // Value device drives
  input  wire logic i_pull_low, // Board holds reset low
  input  wire logic i_go,       // Start a bus cycle
  input  wire logic i_use_rdy,  // Cycle uses ready
  input  wire logic i_late,     // Ready stays inactive
  input  wire logic i_abort,    // Device aborts cycle
  output logic      o_pin,      // Resolved reset pin
  output logic      o_active,   // Bus cycle running
  output logic      o_uses,     // Cycle uses ready
  output logic      o_ws_done,  // Wait states done
  output logic      o_ready_b   // Ready, pulled up
);
  logic [2:0] ws_reg = 3'h0;
  // Pull-up on reset line; any low driver wins
  assign o_pin = !((i_oe && !i_out) || i_pull_low);
  assign o_ws_done = o_active && ws_reg >= 3'h3;
  assign o_ready_b = !(o_ws_done && o_uses && !i_late);
  // Three wait states, ends late or on abort
  initial o_active = 1'b0;
  initial o_uses = 1'b0;
  always @(posedge i_clk) begin
    if (i_go) begin
      o_active <= 1'b1;
      o_uses <= i_use_rdy;
      ws_reg <= 3'h0;
    end else if (o_active && (i_abort || (ws_reg == 3'h7 && !i_late))) begin
      o_active <= 1'b0;
    end else if (o_active && ws_reg != 3'h7) begin
      ws_reg <= ws_reg + 3'h1;
    end
  end
endmodule

// ==== test_watchdog_reset_sequencer.sv ====
`timescale 1ns/1ps
module test_watchdog_reset_sequencer;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
  typedef struct {int len; int oe; logic ab;} note_t;
  note_t notes[$];
  localparam int SW_LEN = wdt_rst_pkg::TRANS_CYCLES + wdt_rst_pkg::SEQ_CYCLES
                          + wdt_rst_pkg::CHECK_CYCLES;
  int n_fail = 0, tests_run = 0, len_c = 0, oe_c = 0, n;
  logic ab_c = 0, q;
  logic i_clk = 0, i_rst_b = 1, i_vpp = 0, i_dis = 0, i_svc = 0, i_init = 0, i_sw = 0;
  logic i_bset = 0, i_bdat = 0, i_boot = 0, i_ps = 0, go = 0, late = 0, pull = 0;
  logic [7:0] i_rel = 8'h00;
  logic pin, act, uses, wsd, rdy_b, irst, rout, rio, roe, tri_s, abrt, hc, bid, run;
  logic [15:0] cnt;
  always #5 i_clk = ~i_clk;
  watchdog_reset_sequencer uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .i_reset_input_pin(pin), .i_vpp_pin(i_vpp), .i_wdt_disable(i_dis), .i_service(i_svc),
    .i_end_of_init(i_init), .i_sw_reset(i_sw), .i_reload_value(i_rel),
    .i_prescale_select(i_ps), .i_bidir_set(i_bset), .i_bidir_wdata(i_bdat),
    .i_bootstrap_mode(i_boot), .i_bus_active(act), .i_bus_uses_ready(uses),
    .i_bus_ws_done(wsd), .i_ready_b(rdy_b), .o_internal_reset(irst), .o_reset_output_pin(rout),
    .o_reset_in_out(rio), .o_reset_in_oe(roe), .o_io_tristate(tri_s), .o_bus_abort(abrt),
    .o_hold_cancel(hc), .o_bidir_enable(bid), .o_wdt_running(run), .o_wdt_count(cnt));
  board_bus_model board (.i_clk(i_clk), .i_oe(roe), .i_out(rio), .i_pull_low(pull),
    .i_go(go), .i_use_rdy(1'b1), .i_late(late), .i_abort(abrt), .o_pin(pin),
    .o_active(act), .o_uses(uses), .o_ws_done(wsd), .o_ready_b(rdy_b));
  // Measures each reset episode and checks it against the oldest note
  always @(posedge i_clk) begin
    if (abrt === 1'b1) ab_c = 1'b1;
    if (irst === 1'b1) begin
      len_c++;
      if (roe === 1'b1) oe_c++;
    end else if (len_c > 0) begin
      if (notes.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        if (notes[0].len != 0) `CHK(len_c, notes[0].len)
        `CHK(oe_c, notes[0].oe)
        `CHK(ab_c, notes[0].ab)
        `CHK(bid, 1'b0)
        `CHK(rio, 1'b0)
        void'(notes.pop_front());
      end
      len_c = 0;
      oe_c = 0;
      ab_c = 1'b0;
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    while (irst !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= lim) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic quiet(input int c);
    q = 1'b0;
    repeat (c) begin
      @(posedge i_clk);
      if (irst !== 1'b0) q = 1'b1;
    end
  endtask
  // Watchdog expiry with bidir drive; its bus cycle is still in flight at expiry only when lt is set
  task automatic wd(input logic [7:0] rel, input logic ps, input logic lt);
    int d;
    i_bset <= 1; i_bdat <= 1; i_rel <= rel; i_ps <= ps; late <= lt;
    @(posedge i_clk); i_bset <= 0; i_svc <= 1;
    @(posedge i_clk); i_svc <= 0; go <= 1;
    @(posedge i_clk); go <= 0;
    @(posedge i_clk);
    `CHK(cnt[15:8], rel)
    notes.push_back('{0, wdt_rst_pkg::SEQ_CYCLES, lt});
    wait_lvl(1, 40000);
    d = (256 - rel) * 256 * (ps ? 128 : 2) - n;
    `CHK((d < 0 ? -d : d) <= (ps ? 144 : 18), 1'b1)
    `CHK(rout, 1'b0)
    wait_lvl(0, 700);
    $display("done: watchdog ps=%0d", ps);
  endtask
  initial begin
    i_rst_b <= 1'b0;
    void'($urandom(68));
    notes.push_back('{0, 0, 1});
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1;
    wait_lvl(0, 700);
    `CHK(rout, 1'b0)
    i_init <= 1; @(posedge i_clk); i_init <= 0; i_dis <= 1; @(posedge i_clk); i_dis <= 0;
    repeat (3) @(posedge i_clk);
    `CHK(rout, 1'b1)
    `CHK(run, 1'b1)
    $display("done: startup");
    i_bset <= 1; i_bdat <= 1; @(posedge i_clk); i_bset <= 0; repeat (2) @(posedge i_clk);
    `CHK(bid, 1'b1)
    notes.push_back('{SW_LEN, wdt_rst_pkg::SEQ_CYCLES, 1});
    i_sw <= 1; @(posedge i_clk); i_sw <= 0;
    wait_lvl(1, 4);
    `CHK(hc, 1'b1)
    wait_lvl(0, 700);
    $display("done: software reset");
    wd(8'hfe | 8'($urandom % 2), 1'b0, 1'b1);
    wd(8'hff, 1'b1, 1'b0);
    i_dis <= 1; @(posedge i_clk); i_dis <= 0; quiet(700);
    `CHK(run, 1'b0)
    `CHK(q, 1'b0)
    notes.push_back('{SW_LEN, 0, 1});
    i_sw <= 1; @(posedge i_clk); i_sw <= 0; wait_lvl(1, 4); wait_lvl(0, 700);
    `CHK(run, 1'b1)
    i_boot <= 1; i_rel <= 8'hff; i_ps <= 0; i_svc <= 1; @(posedge i_clk); i_svc <= 0;
    quiet(700);
    `CHK(q, 1'b0)
    $display("done: disable and bootstrap");
    i_vpp <= 1; pull <= 1; repeat (40) @(posedge i_clk);
    `CHK(tri_s, 1'b1)
    `CHK(rout, 1'b0)
    `CHK(irst, 1'b1)
    notes.push_back('{0, 0, 1});
    pull <= 0; wait_lvl(0, 700); @(posedge i_clk);
    $display("done: warm reset");
    conclude();
  end
endmodule
